/* shared/gpo_pkg.sv */
/*
 * Shared constants and carriers for the observation output mux.
 * Assumes a 32-bit AHB-Lite slave and word indexed registers.
 */
package gpo_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DET_CTRL = 8'h05;
    localparam logic [7:0] IDX_FRAC = 8'h0C;
    localparam logic [7:0] IDX_AUX_CTRL = 8'h18;
    localparam logic [7:0] IDX_OUT_PORT = 8'h1B;
    localparam logic [7:0] IDX_STATUS = 8'h20;

    // Output port register fields
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 4;
    localparam int STATIC_LSB = 4;
    localparam int STATIC_W = 3;

    // Detector control fields
    localparam int PHASE_INV_BIT = 0;
    localparam int UP_EN_BIT = 1;
    localparam int DN_EN_BIT = 2;

    // Auxiliary clock control fields
    localparam int AUX_MODE_LSB = 2;
    localparam int AUX_MODE_W = 2;
    localparam int AUX_DIV_LSB = 4;
    localparam int AUX_DIV_W = 3;

    localparam int FRAC_W = 24;

    // Reset values
    localparam logic [31:0] OUT_PORT_RST = 32'h0000_0000;
    localparam logic [31:0] DET_CTRL_RST = 32'h0000_0006;
    localparam logic [31:0] AUX_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] FRAC_RST = 32'h0000_0000;

    // Source select codes
    localparam logic [3:0] SEL_STATIC = 4'h0;
    localparam logic [3:0] SEL_DIVIDERS = 4'h1;
    localparam logic [3:0] SEL_LOCK_WIN = 4'h2;
    localparam logic [3:0] SEL_SLIP = 4'h3;
    localparam logic [3:0] SEL_FRAC = 4'h4;
    localparam logic [3:0] SEL_ACCUM = 4'h6;
    localparam logic [3:0] SEL_AUX = 4'h7;
    localparam logic [3:0] SEL_MOD_OUT = 4'hA;

    // Internal synthesizer signals watched by the mux
    typedef struct packed {
        logic ref_div;
        logic prescaler;
        logic xtal_buf;
        logic sine_ref;
        logic lock_win;
        logic pfd_up;
        logic pfd_dn;
        logic ref_fast;
        logic vco_fast;
        logic max_gain;
        logic locked;
        logic ring_osc;
        logic mod_clk;
        logic aux_src;
        logic [2:0] acc_msb;
        logic [2:0] mod_lsb;
    } probe_t;

    // Pin order: [2] pin three, [1] pin two, [0] pin one
    typedef struct packed {
        logic three;
        logic two;
        logic one;
    } obs_t;

endpackage : gpo_pkg

/* src/aux_clock_gen.sv */
/*
 * Auxiliary clock shaper: even divider then selectable delay.
 * Assumes aux_src is already synchronised to hclk and slower than hclk/2.
 */
`timescale 1ns/1ns
module aux_clock_gen (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic aux_src,
    input wire logic [gpo_pkg::AUX_MODE_W-1:0] mode,
    input wire logic [gpo_pkg::AUX_DIV_W-1:0] div,
    output logic aux_out
);
    import gpo_pkg::*;

    logic src_prev_reg;
    logic src_rise;
    logic [2:0] edge_cnt_reg;
    logic [2:0] edge_limit;
    logic div_reg;
    logic [2:0] delay_reg;

    assign src_rise = aux_src && !src_prev_reg;
    // Code 7 has no even ratio above 14, so it stays at 14
    assign edge_limit = (div == 3'h7) ? 3'h6 : div;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= aux_src;
        end
    end

    // Toggle every edge_limit+1 source edges: ratio 2*(edge_limit+1)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_cnt_reg <= 3'h0;
            div_reg <= 1'b0;
        end else if (src_rise) begin
            if (edge_cnt_reg >= edge_limit) begin
                edge_cnt_reg <= 3'h0;
                div_reg <= !div_reg;
            end else begin
                edge_cnt_reg <= edge_cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delay_reg <= 3'h0;
            aux_out <= 1'b0;
        end else begin
            delay_reg <= {delay_reg[1:0], div_reg};
            aux_out <= (mode == 2'h0) ? div_reg : delay_reg[mode - 2'h1];
        end
    end

    // Deepest delay: three shift stages plus the output flop
    a_aux_delay: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode == 2'h3) |=> aux_out == $past(div_reg, 4))
        else $error("aux clock delay not applied");

endmodule : aux_clock_gen

/* src/observation_output_mux.sv */
/*
 * Observation output mux with detector pump gating and an AHB-Lite register slave.
 * Assumes probe signals come from other clock domains; single word transfers only.
 */
// Local design decisions: the register offsets and the AHB-Lite register port.
// Summary of operation
// - Select 1 puts buffered crystal on pin three.
// - Select 1 also puts reference divider on pin two, prescaler on pin one.
// - Select 2: lock window pin one, pump up pin three, pump down pin two.
// - Select 3: reference-faster pin three, VCO-faster pin two, gain hold pin one.
// - Faster indicators pass straight through; gain hold stays until lock.
// - Select 4: fractional strobe pin one, reference divider two, sine reference three.
// - Fractional register write makes one synchronous strobe that loads the modulator.
// - Select 6: top three accumulator bits on pins three to one.
// - Select 7: aux clock pin three, ring oscillator two, modulator clock one.
// - Aux clock has two-bit delay mode and even divide 2 to 14.
// - Select 10: low three modulator output bits, lowest on pin one.
// - Detector control bit 0 swaps the detector polarity.
// - Clearing detector control bit 1 masks the pump up output.
// - Clearing detector control bit 2 masks the pump down output.
// - Both gates cleared leaves the pump idle, all else running.
// - Select 0 drives output port bits 6:4 onto the pins.
`timescale 1ns/1ns
module observation_output_mux (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire gpo_pkg::probe_t probe,
    output logic observe_pin_one,
    output logic observe_pin_two,
    output logic observe_pin_three,
    output logic pump_up,
    output logic pump_down,
    output logic frac_strobe,
    output logic [gpo_pkg::FRAC_W-1:0] frac_word
);
    import gpo_pkg::*;

    probe_t sync1_reg;
    probe_t sync2_reg;
    logic [31:0] out_port_reg;
    logic [31:0] det_ctrl_reg;
    logic [31:0] aux_ctrl_reg;
    logic wr_pend_reg;
    logic [7:0] wr_idx_reg;
    logic hold_reg;
    logic aux_clk;
    logic accept;
    logic [7:0] idx;
    logic [3:0] sel;
    logic up_raw;
    logic dn_raw;
    obs_t obs_next;

    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == IDX_DET_CTRL) || (i == IDX_FRAC) || (i == IDX_AUX_CTRL) ||
                    (i == IDX_OUT_PORT) || (i == IDX_STATUS);
    endfunction : is_mapped

    // IDLE and BUSY never start a transfer; only NONSEQ/SEQ with hready do
    assign accept = hsel && htrans[1] && hready;
    assign idx = haddr[9:2];
    assign sel = out_port_reg[SEL_LSB +: SEL_W];

    // Every probe crosses in through two flops before any use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= probe;
            sync2_reg <= sync1_reg;
        end
    end

    // Zero wait state slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
        end else begin
            wr_pend_reg <= accept && hwrite;
            wr_idx_reg <= idx;
        end
    end

    // Read data latched in the address phase; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (accept && !hwrite) begin
            if (!is_mapped(idx)) begin
                hrdata <= 32'h0000_0000;
            end else if (idx == IDX_DET_CTRL) begin
                hrdata <= det_ctrl_reg;
            end else if (idx == IDX_FRAC) begin
                hrdata <= {8'h00, frac_word};
            end else if (idx == IDX_AUX_CTRL) begin
                hrdata <= aux_ctrl_reg;
            end else if (idx == IDX_OUT_PORT) begin
                hrdata <= out_port_reg;
            end else begin
                hrdata <= {26'h0, hold_reg, pump_down, pump_up,
                           observe_pin_three, observe_pin_two, observe_pin_one};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_port_reg <= OUT_PORT_RST;
            det_ctrl_reg <= DET_CTRL_RST;
            aux_ctrl_reg <= AUX_CTRL_RST;
        end else if (wr_pend_reg) begin
            if (wr_idx_reg == IDX_OUT_PORT) begin
                out_port_reg <= {25'h0, hwdata[STATIC_LSB +: STATIC_W], hwdata[SEL_LSB +: SEL_W]};
            end
            if (wr_idx_reg == IDX_DET_CTRL) begin
                det_ctrl_reg <= {29'h0, hwdata[DN_EN_BIT], hwdata[UP_EN_BIT], hwdata[PHASE_INV_BIT]};
            end
            if (wr_idx_reg == IDX_AUX_CTRL) begin
                aux_ctrl_reg <= {25'h0, hwdata[AUX_DIV_LSB +: AUX_DIV_W],
                                 hwdata[AUX_MODE_LSB +: AUX_MODE_W], 2'b00};
            end
        end
    end

    // Strobe is born in the hclk domain, so it is already synchronous
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frac_word <= FRAC_RST[FRAC_W-1:0];
            frac_strobe <= 1'b0;
        end else begin
            frac_strobe <= wr_pend_reg && (wr_idx_reg == IDX_FRAC);
            if (wr_pend_reg && (wr_idx_reg == IDX_FRAC)) begin
                frac_word <= hwdata[FRAC_W-1:0];
            end
        end
    end

    // Set wins over the lock clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_reg <= 1'b0;
        end else if (sync2_reg.max_gain) begin
            hold_reg <= 1'b1;
        end else if (sync2_reg.locked) begin
            hold_reg <= 1'b0;
        end
    end

    assign up_raw = det_ctrl_reg[PHASE_INV_BIT] ? sync2_reg.pfd_dn : sync2_reg.pfd_up;
    assign dn_raw = det_ctrl_reg[PHASE_INV_BIT] ? sync2_reg.pfd_up : sync2_reg.pfd_dn;

    // Gating only affects the pump; detector itself keeps running
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pump_up <= 1'b0;
            pump_down <= 1'b0;
        end else begin
            pump_up <= up_raw && det_ctrl_reg[UP_EN_BIT];
            pump_down <= dn_raw && det_ctrl_reg[DN_EN_BIT];
        end
    end

    aux_clock_gen u_aux (
        .hclk(hclk),
        .hresetn(hresetn),
        .aux_src(sync2_reg.aux_src),
        .mode(aux_ctrl_reg[AUX_MODE_LSB +: AUX_MODE_W]),
        .div(aux_ctrl_reg[AUX_DIV_LSB +: AUX_DIV_W]),
        .aux_out(aux_clk)
    );

    // Unlisted codes fall to the default, so a stray write cannot float a pin
    always_comb begin
        obs_next = '0;
        case (sel)
            SEL_STATIC: obs_next = out_port_reg[STATIC_LSB +: STATIC_W];
            SEL_DIVIDERS: obs_next = {sync2_reg.xtal_buf, sync2_reg.ref_div, sync2_reg.prescaler};
            SEL_LOCK_WIN: obs_next = {pump_up, pump_down, sync2_reg.lock_win};
            SEL_SLIP: obs_next = {sync2_reg.ref_fast, sync2_reg.vco_fast, hold_reg};
            SEL_FRAC: obs_next = {sync2_reg.sine_ref, sync2_reg.ref_div, frac_strobe};
            SEL_ACCUM: obs_next = sync2_reg.acc_msb;
            SEL_AUX: obs_next = {aux_clk, sync2_reg.ring_osc, sync2_reg.mod_clk};
            SEL_MOD_OUT: obs_next = sync2_reg.mod_lsb;
            default: obs_next = '0;
        endcase
    end

    // Registered pins: the far side never sees a decode glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            observe_pin_one <= 1'b0;
            observe_pin_two <= 1'b0;
            observe_pin_three <= 1'b0;
        end else begin
            observe_pin_one <= obs_next.one;
            observe_pin_two <= obs_next.two;
            observe_pin_three <= obs_next.three;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence frac_write_s;
        wr_pend_reg && (wr_idx_reg == IDX_FRAC);
    endsequence

    sequence single_strobe_s;
        frac_strobe ##1 !frac_strobe;
    endsequence

    a_frac_strobe_pulse: assert property (frac_write_s |=> single_strobe_s)
        else $error("fractional write did not give one strobe");
    a_frac_word_load: assert property (frac_write_s |=> frac_word == $past(hwdata[FRAC_W-1:0]))
        else $error("fractional word not loaded");
    a_sel_dividers: assert property ((sel == SEL_DIVIDERS) && $past(sel == SEL_DIVIDERS)
        |-> observe_pin_three == $past(sync2_reg.xtal_buf) && observe_pin_two == $past(sync2_reg.ref_div)
            && observe_pin_one == $past(sync2_reg.prescaler))
        else $error("crystal or divider outputs not on pins");
    a_sel_static: assert property ((sel == SEL_STATIC) ##1 (sel == SEL_STATIC)
        |-> {observe_pin_three, observe_pin_two, observe_pin_one} == $past(out_port_reg[STATIC_LSB +: STATIC_W]))
        else $error("static bits not on pins");
    a_sel_window: assert property ((sel == SEL_LOCK_WIN) ##1 (sel == SEL_LOCK_WIN)
        |-> observe_pin_three == $past(pump_up) && observe_pin_two == $past(pump_down)
            && observe_pin_one == $past(sync2_reg.lock_win))
        else $error("window or pump pulses not on pins");
    a_sel_accum: assert property ((sel == SEL_ACCUM) ##1 (sel == SEL_ACCUM)
        |-> {observe_pin_three, observe_pin_two, observe_pin_one} == $past(sync2_reg.acc_msb))
        else $error("accumulator bits misplaced");
    a_sel_modout: assert property ((sel == SEL_MOD_OUT) ##1 (sel == SEL_MOD_OUT)
        |-> {observe_pin_three, observe_pin_two, observe_pin_one} == $past(sync2_reg.mod_lsb))
        else $error("modulator low bits misplaced");
    a_sel_undefined: assert property ((sel == 4'h5 || sel == 4'h8 || sel == 4'h9 || sel > SEL_MOD_OUT) [*2]
        |-> !observe_pin_one && !observe_pin_two && !observe_pin_three)
        else $error("undefined select drives a pin");
    a_up_masked: assert property (!det_ctrl_reg[UP_EN_BIT] [*2] |-> !pump_up)
        else $error("pump up while masked");
    a_down_masked: assert property (!det_ctrl_reg[DN_EN_BIT] [*2] |-> !pump_down)
        else $error("pump down while masked");
    a_phase_invert: assert property (det_ctrl_reg[PHASE_INV_BIT] && det_ctrl_reg[UP_EN_BIT]
        |=> pump_up == $past(sync2_reg.pfd_dn))
        else $error("polarity swap not applied");
    a_hold_until_lock: assert property (hold_reg && !sync2_reg.locked |=> hold_reg)
        else $error("gain hold dropped before lock");
    a_hold_set: assert property (sync2_reg.max_gain |=> hold_reg)
        else $error("gain hold not set");
    a_down_invert: assert property (det_ctrl_reg[PHASE_INV_BIT] && det_ctrl_reg[DN_EN_BIT]
        |=> pump_down == $past(sync2_reg.pfd_up))
        else $error("polarity swap not applied to pump down");
    a_pump_idle: assert property (!det_ctrl_reg[UP_EN_BIT] && !det_ctrl_reg[DN_EN_BIT]
        |=> !pump_up && !pump_down)
        else $error("pump active with both gates cleared");
    a_strobe_source: assert property (frac_strobe |-> $past(wr_pend_reg && (wr_idx_reg == IDX_FRAC)))
        else $error("fractional strobe without a write");

    // Control bits land at the end of the data phase
    a_det_write: assert property (wr_pend_reg && (wr_idx_reg == IDX_DET_CTRL)
        |=> det_ctrl_reg[DN_EN_BIT:PHASE_INV_BIT] == $past(hwdata[DN_EN_BIT:PHASE_INV_BIT]))
        else $error("detector control write lost");
    a_port_read: assert property (accept && !hwrite && (idx == IDX_OUT_PORT)
        |=> hrdata == $past(out_port_reg))
        else $error("output port read back wrong");

    // Pins are registered, so each one shows its source one cycle back
    sequence sel_held_s(logic [3:0] code);
        (sel == code) ##1 (sel == code);
    endsequence

    a_sel_slip: assert property (sel_held_s(SEL_SLIP)
        |-> observe_pin_three == $past(sync2_reg.ref_fast) && observe_pin_two == $past(sync2_reg.vco_fast)
            && observe_pin_one == $past(hold_reg))
        else $error("slip indicators not on pins");
    a_sel_frac: assert property (sel_held_s(SEL_FRAC)
        |-> observe_pin_three == $past(sync2_reg.sine_ref) && observe_pin_two == $past(sync2_reg.ref_div)
            && observe_pin_one == $past(frac_strobe))
        else $error("strobe or reference not on pins");
    a_sel_aux: assert property (sel_held_s(SEL_AUX)
        |-> observe_pin_three == $past(aux_clk) && observe_pin_two == $past(sync2_reg.ring_osc)
            && observe_pin_one == $past(sync2_reg.mod_clk))
        else $error("auxiliary clocks not on pins");

endmodule : observation_output_mux

/* verification/pin_observer.sv */
/*
 * Instrument model watching the observation pins: counts pin one rises, times pin three.
 * Assumes pins are synchronous to hclk and only ever observed, never driven.
 */
`timescale 1ns/1ns
module pin_observer (
    input wire logic hclk,
    input wire logic pin_one,
    input wire logic pin_three,
    output int one_rises,
    output int three_period
);
    logic one_q;
    logic three_q;
    int since;

    // Trigger input of the instrument, counted per rising edge
    always @(posedge hclk) begin
        one_q <= pin_one;
        if (pin_one && !one_q) begin
            one_rises <= one_rises + 1;
        end
    end

    // Period between rises; the first figure after a change is a partial one
    always @(posedge hclk) begin
        three_q <= pin_three;
        if (pin_three && !three_q) begin
            three_period <= since + 1;
            since <= 0;
        end else begin
            since <= since + 1;
        end
    end
endmodule : pin_observer

/* verification/observation_output_mux_tb.sv */
/*
 * Self-checking bench for the observation output mux, table driven then hand tests.
 * Assumes the single AHB-Lite slave answers at once and probe levels take a few cycles.
 */
`timescale 1ns/1ns
module observation_output_mux_tb;
    import gpo_pkg::*;
    typedef struct packed {
        logic [7:0] port;
        logic [19:0] pr;
        logic [2:0] exp;
        logic [2:0] msk;
    } row_t;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, obs;
    probe_t probe;
    logic observe_pin_one, observe_pin_two, observe_pin_three, pump_up, pump_down, frac_strobe;
    logic [FRAC_W-1:0] frac_word;
    int n_fail, n_compared, one_rises, three_period, base, ratio;
    logic [7:0] aux_cfg [3] = '{8'h00, 8'h2C, 8'h70};
    // Gain hold is latched by the all-ones probe of row 0, so pin one is masked in select 3
    row_t rows [23] = '{
        '{8'h50, 20'hFFFFF, 3'h5, 3'h7}, '{8'h20, 20'h00000, 3'h2, 3'h7},
        '{8'h01, 20'h20000, 3'h4, 3'h7}, '{8'h01, 20'hC0000, 3'h3, 3'h7},
        '{8'h02, 20'h0A000, 3'h3, 3'h7}, '{8'h02, 20'h04000, 3'h4, 3'h7},
        '{8'h03, 20'h01000, 3'h4, 3'h6}, '{8'h03, 20'h00800, 3'h2, 3'h6},
        '{8'h04, 20'h90000, 3'h6, 3'h7}, '{8'h06, 20'h00020, 3'h4, 3'h7},
        '{8'h06, 20'h00018, 3'h3, 3'h7}, '{8'h07, 20'h00100, 3'h2, 3'h3},
        '{8'h07, 20'h00080, 3'h1, 3'h3}, '{8'h0A, 20'h00001, 3'h1, 3'h7},
        '{8'h0A, 20'h00006, 3'h6, 3'h7}, '{8'h05, 20'hFFFFF, 3'h0, 3'h7},
        '{8'h08, 20'hFFFFF, 3'h0, 3'h7}, '{8'h09, 20'hFFFFF, 3'h0, 3'h7},
        '{8'h0B, 20'hFFFFF, 3'h0, 3'h7}, '{8'h0C, 20'hFFFFF, 3'h0, 3'h7},
        '{8'h0D, 20'hFFFFF, 3'h0, 3'h7}, '{8'h0E, 20'hFFFFF, 3'h0, 3'h7},
        '{8'h0F, 20'hFFFFF, 3'h0, 3'h7}};

    assign obs = {observe_pin_three, observe_pin_two, observe_pin_one};

    observation_output_mux observation_output_mux_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .probe(probe),
        .observe_pin_one(observe_pin_one), .observe_pin_two(observe_pin_two),
        .observe_pin_three(observe_pin_three), .pump_up(pump_up), .pump_down(pump_down),
        .frac_strobe(frac_strobe), .frac_word(frac_word));
    pin_observer pin_observer_inst (.hclk(hclk), .pin_one(observe_pin_one), .pin_three(observe_pin_three),
        .one_rises(one_rises), .three_period(three_period));

    initial begin
        hclk = 1'b0;
    end
    always #2 hclk = ~hclk;

    task wrap_up;
        $display("counts: compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk

    // Address phase held until hready, then data phase held until hready again
    task ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        haddr <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : ahb

    task settle;
        repeat (6) @(posedge hclk);
        @(negedge hclk);
    endtask : settle

    initial begin
        #(4 * 30000);
        n_fail++;
        wrap_up;
    end

    initial begin
        n_fail = 0;
        n_compared = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        probe = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("pins_in_reset", 32'h0, {29'h0, obs});
        ahb(1'b0, IDX_DET_CTRL, 32'h0, rd);
        chk("det_ctrl_reset", DET_CTRL_RST, rd);
        chk("hresp_okay", 32'h0, {31'h0, hresp});
        ahb(1'b0, IDX_OUT_PORT, 32'h0, rd);
        chk("out_port_reset", OUT_PORT_RST, rd);
        ahb(1'b0, IDX_AUX_CTRL, 32'h0, rd);
        chk("aux_ctrl_reset", AUX_CTRL_RST, rd);
        ahb(1'b0, IDX_FRAC, 32'h0, rd);
        chk("frac_reset", FRAC_RST, rd);
        ahb(1'b1, 8'h33, 32'hFFFF_FFFF, rd);
        ahb(1'b0, 8'h33, 32'h0, rd);
        chk("unmapped_read", 32'h0, rd);
        $display("test reset and registers done");

        foreach (rows[i]) begin
            @(posedge hclk);
            probe <= rows[i].pr;
            ahb(1'b1, IDX_OUT_PORT, {24'h0, rows[i].port}, rd);
            settle;
            chk("pins", {29'h0, rows[i].exp & rows[i].msk}, {29'h0, obs & rows[i].msk});
        end
        $display("test select table done");

        @(posedge hclk);
        probe <= 20'h04000;
        for (int d = 0; d < 8; d++) begin
            ahb(1'b1, IDX_DET_CTRL, d, rd);
            settle;
            chk("pump_up", {31'h0, ~d[0] & d[1]}, {31'h0, pump_up});
            chk("pump_down", {31'h0, d[0] & d[2]}, {31'h0, pump_down});
        end
        @(posedge hclk);
        probe <= 20'h06000;
        ahb(1'b1, IDX_DET_CTRL, 32'h0, rd);
        ahb(1'b1, IDX_OUT_PORT, {28'h0, SEL_LOCK_WIN}, rd);
        settle;
        chk("pumps_idle", 32'h0, {29'h0, obs[2:1], pump_up | pump_down});
        ahb(1'b1, IDX_DET_CTRL, DET_CTRL_RST, rd);
        $display("test pump gating done");

        ahb(1'b1, IDX_OUT_PORT, {28'h0, SEL_FRAC}, rd);
        settle;
        base = one_rises;
        ahb(1'b1, IDX_FRAC, 32'hFFAB_CDEF, rd);
        ahb(1'b1, IDX_FRAC, 32'h0012_3456, rd);
        settle;
        chk("frac_word", 32'h0012_3456, {8'h0, frac_word});
        chk("frac_strobes", 32'd2, one_rises - base);
        ahb(1'b0, IDX_FRAC, 32'h0, rd);
        chk("frac_read", 32'h0012_3456, rd);
        $display("test frac strobe done");

        // Hold is still latched from the table, so clear it first, then set it
        ahb(1'b1, IDX_OUT_PORT, {28'h0, SEL_SLIP}, rd);
        @(posedge hclk);
        probe <= 20'h00200;
        repeat (4) @(posedge hclk);
        probe <= 20'h00000;
        settle;
        chk("gain_hold_clear", 32'h0, {31'h0, observe_pin_one});
        @(posedge hclk);
        probe <= 20'h00400;
        repeat (4) @(posedge hclk);
        probe <= 20'h00000;
        settle;
        chk("gain_hold_set", 32'h1, {31'h0, observe_pin_one});
        ahb(1'b0, IDX_STATUS, 32'h0, rd);
        chk("status", 32'h0000_0021, rd);
        $display("test gain hold done");

        ahb(1'b1, IDX_OUT_PORT, {28'h0, SEL_AUX}, rd);
        foreach (aux_cfg[k]) begin
            ratio = (aux_cfg[k][6:4] == 3'h7) ? 14 : 2 * (aux_cfg[k][6:4] + 1);
            ahb(1'b1, IDX_AUX_CTRL, {24'h0, aux_cfg[k]}, rd);
            repeat (6 * ratio) begin
                repeat (8) @(posedge hclk);
                probe.aux_src <= ~probe.aux_src;
            end
            // Sync, divider and deepest delay outlast the final half period
            repeat (16) @(posedge hclk);
            @(negedge hclk);
            chk("aux_period", 16 * ratio, three_period);
        end
        $display("test aux clock done");
        wrap_up;
    end
endmodule : observation_output_mux_tb
